/* verilog/rxf_pkg.sv */
// constants for the receiver fault flag block
package rxf_pkg;
  localparam int          RXF_AW        = 7;
  localparam int          RXF_DW        = 8;
  localparam logic [6:0]  RXF_FLAGS_ADR = 7'h18;
  localparam logic [6:0]  RXF_MASK_ADR  = 7'h19;
  localparam logic [7:0]  RXF_MASK_RST  = 8'h00;
  localparam logic [7:0]  RXF_DATA_RST  = 8'h00;
  localparam int          RXF_B_VALID   = 7;
  localparam int          RXF_B_EMPH    = 6;
  localparam int          RXF_B_NA_CS   = 5;
  localparam int          RXF_B_NA_PRE  = 4;
  localparam int          RXF_B_CRC     = 3;
  localparam int          RXF_B_NOSTR   = 2;
  localparam int          RXF_B_BIPHASE = 1;
  localparam int          RXF_B_LOCK    = 0;
  localparam logic [7:0]  RXF_STICKY    = 8'h0A;
endpackage : rxf_pkg

/* verilog/rxf_flag_cell.sv */
// one flag bit with its pending interrupt event
`timescale 1ns/10ps
`default_nettype none
module rxf_flag_cell #(
  parameter bit STICKY = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // condition
  input  wire logic level_in,
  input  wire logic event_in,
  // acknowledge by read
  input  wire logic ack,
  // state
  output var  logic flag_r,
  output var  logic pend_r
);
  logic hit;

  // sticky bits set on event pulse, level bits on any change
  assign hit = STICKY ? event_in : ((level_in != flag_r) | event_in);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (STICKY) begin
      flag_r <= event_in | (flag_r & ~ack);
    end else begin
      flag_r <= level_in;
    end
  end

  // new event wins over acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= hit | (pend_r & ~ack);
    end
  end
endmodule : rxf_flag_cell
`default_nettype wire

/* verilog/rxf_fault_flags.sv */
// receiver fault flag register, mask and interrupt
// What this block does
// - read-only fault register at 0x18, bits 7..0
// - emphasis level; interrupt only on change
// - non-audio level; interrupt on change or type
// - preamble non-audio level; interrupt on change
// - checksum fault sticky until register read
// - no-stream level; interrupt only on change
// - biphase/parity fault sticky until read
// - lock follows PLL; interrupt on change
// - mask bit one enables flag interrupt
`timescale 1ns/10ps
`default_nettype none
module rxf_fault_flags
  import rxf_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // register port
  input  wire logic [RXF_AW-1:0] reg_addr,
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  input  wire logic [RXF_DW-1:0] reg_wdata,
  output var  logic [RXF_DW-1:0] reg_rdata_r,
  // receiver status
  input  wire logic              received_valid_flag,
  input  wire logic              emphasis_in,
  input  wire logic              nonaudio_cs_in,
  input  wire logic              nonaudio_type_chg,
  input  wire logic              nonaudio_pre_in,
  input  wire logic              status_checksum_fault,
  input  wire logic              no_stream_in,
  input  wire logic              biphase_err,
  input  wire logic              pll_lock_in,
  // interrupt
  output var  logic              irq_r
);
  logic [7:0] lvl;
  logic [7:0] evt;
  logic [7:0] flags;
  logic [7:0] pend;
  logic [7:0] mask_r;
  logic       ack;

  function automatic logic hit_adr(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction : hit_adr

  assign ack = reg_rd & hit_adr(reg_addr, RXF_FLAGS_ADR);

  always_comb begin
    lvl = 8'h00;
    evt = 8'h00;
    lvl[RXF_B_VALID]   = received_valid_flag;
    lvl[RXF_B_EMPH]    = emphasis_in;
    lvl[RXF_B_NA_CS]   = nonaudio_cs_in;
    evt[RXF_B_NA_CS]   = nonaudio_type_chg;
    lvl[RXF_B_NA_PRE]  = nonaudio_pre_in;
    evt[RXF_B_CRC]     = status_checksum_fault;
    lvl[RXF_B_NOSTR]   = no_stream_in;
    evt[RXF_B_BIPHASE] = biphase_err;
    lvl[RXF_B_LOCK]    = pll_lock_in;
  end

  // per-bit flag and event cells
  generate
    for (genvar i = 0; i < 8; i++) begin : g_cell
      rxf_flag_cell #(.STICKY(RXF_STICKY[i])) u_cell (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .level_in (lvl[i]),
        .event_in (evt[i]),
        .ack      (ack),
        .flag_r   (flags[i]),
        .pend_r   (pend[i])
      );
    end
  endgenerate

  // mask register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= RXF_MASK_RST;
    end else if (reg_wr && hit_adr(reg_addr, RXF_MASK_ADR)) begin
      mask_r <= reg_wdata;
    end
  end

  // read data, fault register is read-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= RXF_DATA_RST;
    end else if (reg_rd) begin
      if (hit_adr(reg_addr, RXF_FLAGS_ADR)) begin
        reg_rdata_r <= flags;
      end else if (hit_adr(reg_addr, RXF_MASK_ADR)) begin
        reg_rdata_r <= mask_r;
      end else begin
        reg_rdata_r <= RXF_DATA_RST;
      end
    end
  end

  // interrupt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(pend & mask_r);
    end
  end

  a_flag_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ack |=> reg_rdata_r == $past(flags))
    else $error("fault register read returned wrong data");

  a_emph_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (emphasis_in != flags[RXF_B_EMPH]) |=> pend[RXF_B_EMPH])
    else $error("emphasis change raised no event");

  a_natype_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nonaudio_type_chg |=> pend[RXF_B_NA_CS])
    else $error("non-audio type change raised no event");

  a_pre_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && nonaudio_pre_in == flags[RXF_B_NA_PRE])
      |=> !pend[RXF_B_NA_PRE])
    else $error("preamble event remained after read");

  a_crc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flags[RXF_B_CRC] && !ack) |=> flags[RXF_B_CRC])
    else $error("checksum fault dropped without read");

  a_crc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && !status_checksum_fault) |=> !flags[RXF_B_CRC])
    else $error("checksum fault not cleared by read");

  a_nostr_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && no_stream_in == flags[RXF_B_NOSTR])
      |=> !pend[RXF_B_NOSTR] && flags[RXF_B_NOSTR] == $past(no_stream_in))
    else $error("no-stream bit changed or kept event after read");

  a_bip_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    biphase_err |=> flags[RXF_B_BIPHASE] && pend[RXF_B_BIPHASE])
    else $error("biphase fault not captured");

  a_lock_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> flags[RXF_B_LOCK] == $past(pll_lock_in))
    else $error("lock bit does not follow pll");

  a_mask_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mask_r == 8'h00) [*2] |-> !irq_r)
    else $error("interrupt with all masks clear");

  a_irq_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> irq_r == $past(|(pend & mask_r)))
    else $error("interrupt not tied to masked events");

  a_valid_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> flags[RXF_B_VALID] == $past(received_valid_flag))
    else $error("validity bit does not follow input");

  a_emph_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> flags[RXF_B_EMPH] == $past(emphasis_in))
    else $error("emphasis bit does not follow input");

  a_na_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> flags[RXF_B_NA_CS] == $past(nonaudio_cs_in))
    else $error("non-audio bit does not follow input");

  a_na_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && !nonaudio_type_chg && nonaudio_cs_in == flags[RXF_B_NA_CS])
      |=> !pend[RXF_B_NA_CS])
    else $error("non-audio event remained after read");

  a_pre_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (nonaudio_pre_in != flags[RXF_B_NA_PRE]) |=> pend[RXF_B_NA_PRE])
    else $error("preamble change raised no event");

  a_crc_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    status_checksum_fault |=> flags[RXF_B_CRC] && pend[RXF_B_CRC])
    else $error("checksum fault not captured");

  a_nostr_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (no_stream_in != flags[RXF_B_NOSTR]) |=> pend[RXF_B_NOSTR])
    else $error("no-stream change raised no event");

  a_bip_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flags[RXF_B_BIPHASE] && !ack) |=> flags[RXF_B_BIPHASE])
    else $error("biphase fault dropped without read");

  a_bip_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && !biphase_err) |=> !flags[RXF_B_BIPHASE])
    else $error("biphase fault not cleared by read");

  a_lock_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pll_lock_in != flags[RXF_B_LOCK]) |=> pend[RXF_B_LOCK])
    else $error("lock change raised no event");

  a_lock_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && pll_lock_in == flags[RXF_B_LOCK]) |=> !pend[RXF_B_LOCK])
    else $error("lock event remained after read");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && hit_adr(reg_addr, RXF_MASK_ADR))
      |=> mask_r == $past(reg_wdata))
    else $error("mask write not taken");

  a_mask_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && hit_adr(reg_addr, RXF_MASK_ADR))
      |=> reg_rdata_r == $past(mask_r))
    else $error("mask read returned wrong data");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && !hit_adr(reg_addr, RXF_FLAGS_ADR)
      && !hit_adr(reg_addr, RXF_MASK_ADR))
      |=> reg_rdata_r == RXF_DATA_RST)
    else $error("unmapped read not zero");

  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ack && evt == 8'h00 && ((lvl ^ flags) & ~RXF_STICKY) == 8'h00)
      |=> pend == 8'h00)
    else $error("read did not acknowledge events");

  a_pend_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pend[RXF_B_CRC] && !ack) |=> pend[RXF_B_CRC])
    else $error("checksum event dropped without read");
endmodule : rxf_fault_flags
`default_nettype wire

/* tb/test_rxf_fault_flags.sv */
// self-checking bench for the receiver fault flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g,e) begin checks_done++; if ((g)!==(e)) begin n_mismatch++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_rxf_fault_flags
  import rxf_pkg::*;
;
  logic       clk_sys = 0;
  logic       rst_n = 0;
  logic [6:0] reg_addr = 7'h00;
  logic       reg_rd = 0;
  logic       reg_wr = 0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] lvl = 8'h00;
  logic [7:0] pls = 8'h00;
  logic [7:0] reg_rdata_r;
  logic       irq_r;
  logic [7:0] m_flag, m_pend, m_mask, m_rd, ev;
  logic       m_irq;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         cyc = 0;
  rxf_fault_flags u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .received_valid_flag(lvl[7]), .emphasis_in(lvl[6]),
    .nonaudio_cs_in(lvl[5]), .nonaudio_type_chg(pls[5]),
    .nonaudio_pre_in(lvl[4]), .status_checksum_fault(pls[3]),
    .no_stream_in(lvl[2]), .biphase_err(pls[1]),
    .pll_lock_in(lvl[0]), .irq_r(irq_r));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // reference of flags, events, mask and interrupt
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m_flag <= 8'h00; m_pend <= 8'h00; m_mask <= RXF_MASK_RST;
      m_rd <= 8'h00; m_irq <= 1'b0;
    end else begin
      ev = ((lvl ^ m_flag) & ~RXF_STICKY) | (pls & 8'h2A);
      m_irq <= |(m_pend & m_mask);
      if (reg_rd) m_rd <= (reg_addr == RXF_FLAGS_ADR) ? m_flag :
                          (reg_addr == RXF_MASK_ADR) ? m_mask : 8'h00;
      if (reg_wr && reg_addr == RXF_MASK_ADR) m_mask <= reg_wdata;
      m_flag <= (lvl & ~RXF_STICKY) | (pls & RXF_STICKY) |
        (m_flag & RXF_STICKY & {8{!(reg_rd && reg_addr == RXF_FLAGS_ADR)}});
      m_pend <= ev | (m_pend & {8{!(reg_rd && reg_addr == RXF_FLAGS_ADR)}});
    end
  end
  always @(negedge clk_sys) begin
    if (rst_n) begin
      `CHK(reg_rdata_r, m_rd)
      `CHK(irq_r, m_irq)
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a; reg_rd = 1; tick(); reg_rd = 0; tick();
    `CHK(reg_rdata_r, e)
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1; tick(); reg_wr = 0; tick();
  endtask : wr
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(90766));
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1;
    tick();
    rd(RXF_MASK_ADR, RXF_MASK_RST);
    wr(RXF_MASK_ADR, 8'hFF);
    pls = 8'h0A; tick(); pls = 8'h00; tick();
    `CHK(irq_r, 1'b1)
    rd(RXF_FLAGS_ADR, 8'h0A);
    rd(RXF_FLAGS_ADR, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lvl = 8'($urandom) & ~RXF_STICKY; tick(); tick();
      rd(RXF_FLAGS_ADR, lvl);
      rd(RXF_FLAGS_ADR, lvl);
      `CHK(irq_r, 1'b0)
      wr(RXF_FLAGS_ADR, 8'hFF);
      rd(RXF_FLAGS_ADR, lvl);
      rd(7'h20, 8'h00);
    end
    repeat (4000) begin
      tick();
      reg_rd = ($urandom % 4) == 0;
      reg_wr = ($urandom % 8) == 0;
      reg_addr = ($urandom % 2) ? RXF_FLAGS_ADR : 7'(23 + $urandom % 4);
      reg_wdata = 8'($urandom);
      if ($urandom % 16 == 0) lvl = lvl ^ (8'($urandom) & ~RXF_STICKY);
      pls = ($urandom % 4 == 0) ? (8'($urandom) & 8'h2A) : 8'h00;
    end
    tick();
    wrap_up();
  end
endmodule : test_rxf_fault_flags
`default_nettype wire
